//--- rtl/cim_params.svh
// Constants for the CPU idle mode controller: register map, fields, reset values, counts.
// Assumes it is included by bare name from the package and the design modules.
`ifndef CIM_PARAMS_SVH
`define CIM_PARAMS_SVH
// Register indices; the byte address on the bus is four times the index.
`define CIM_PWR_CTRL_IDX   8'h87
`define CIM_STATUS_IDX     8'h88
`define CIM_ADDR_W         12
// Power control register fields.
`define CIM_IDLE_BIT       0
`define CIM_PDOWN_BIT      1
`define CIM_FLAG0_BIT      2
`define CIM_FLAG1_BIT      3
`define CIM_PWR_RST        4'h0
// Interrupt sources seen by the wake logic.
`define CIM_NIRQ           8
// Cycles that execution resumes after a pin reset before the reset sequence takes over.
`define CIM_RESUME_CYC     3'h4
// Address from which execution restarts after the reset sequence.
`define CIM_RESET_VECTOR   16'h0000
// Bus responses.
`define CIM_RESP_OKAY      2'h0
`define CIM_RESP_SLVERR    2'h2
`endif

//--- rtl/cim_pkg.sv
// Types for the CPU idle mode controller.
// Assumes the constants header sits beside it.
package cim_pkg;
  `include "cim_params.svh"
  // Gray codes along run, idle, resume, reset sequence.
  typedef enum logic [2:0] {
    CIM_RUN    = 3'h0,
    CIM_IDLE   = 3'h1,
    CIM_RESUME = 3'h3,
    CIM_RSTSEQ = 3'h2,
    CIM_PDOWN  = 3'h6
  } cim_state_t;
endpackage

//--- rtl/cim_sync.sv
// Two flip-flop level synchroniser.
// Assumes the input is asynchronous to aclk and only the second stage is read.
`timescale 1ns/1ps
module cim_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

//--- rtl/cim_top.sv
// CPU idle mode controller with an AXI4-Lite register slave.
// Assumes the core freezes on cpu_freeze and gates its clock with cpu_clk_en.
// Summary of operation
// RULE1 - Idle starts right after the register write setting the idle bit completes.
// RULE2 - In idle the CPU clock stops and execution halts; peripherals keep clocking.
// RULE3 - Program counter, status word, special registers and RAM hold during idle.
// RULE4 - Idle and power-down set together gives power-down, never idle after it.
// RULE5 - An enabled interrupt in idle clears the bit, restarts clock, starts the handler.
// RULE6 - After that handler returns, execution continues after the idle request.
// RULE7 - Two general flags are readable and writable by software.
// RULE8 - A high reset pin clears the idle bit and restores the CPU clock.
// RULE9 - After a reset exit, execution resumes briefly, then reset restarts from zero.
// RULE10 - During that brief resumption internal RAM is blocked, port pins stay accessible.
// RULE11 - Software avoids port or external RAM writes right after the idle request.
// RULE12 - Idle bit 0, power-down bit 1, flags bits 2 and 3, all reset zero.
// RULE13 - In idle ports keep data, port 0 floats for external code, strobes high.
// RULE14 - Only interrupts enabled individually and globally wake the device.
// RULE15 - Idle bit reads one while idle, zero after exit; writing zero does nothing.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "cim_params.svh"
module cim_top
  import cim_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`CIM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`CIM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   rst_pin,
  input  wire logic [`CIM_NIRQ-1:0]   irq_pending,
  input  wire logic [`CIM_NIRQ-1:0]   irq_enable,
  input  wire logic                   irq_global_en,
  input  wire logic                   ext_code,
  output logic                        cpu_clk_en,
  output logic                        periph_clk_en,
  output logic                        cpu_freeze,
  output logic                        isr_start,
  output logic                        ram_block,
  output logic                        core_reset,
  output logic [15:0]                 reset_vector,
  output logic                        port0_float,
  output logic                        ale_hold_high,
  output logic                        psen_hold_high
);
  cim_state_t             state_q;
  cim_state_t             state_d;
  logic                   rst_s;
  logic [`CIM_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic [1:0]             flags_q;
  logic [2:0]             resume_cnt_q;
  logic                   wr_fire;
  logic                   wr_pwr;
  logic                   wake;
  logic [`CIM_ADDR_W-1:0] pwr_addr;
  logic [`CIM_ADDR_W-1:0] stat_addr;

  assign pwr_addr  = {2'h0, `CIM_PWR_CTRL_IDX, 2'h0};
  assign stat_addr = {2'h0, `CIM_STATUS_IDX, 2'h0};

  // Reset pin is asynchronous, so it is synchronised; this costs two cycles of latency.
  cim_sync u_rst_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rst_pin),
    .dout    (rst_s)
  );

  // Write fires once address and data are both held and no response is pending.
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_pwr  = wr_fire && (awaddr_q == pwr_addr) && wstrb_q[0];
  assign wake    = irq_global_en && |(irq_pending & irq_enable); // RULE14

  // Address and data channels are taken independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CIM_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == pwr_addr || awaddr_q == stat_addr) ?
                      `CIM_RESP_OKAY : `CIM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; the idle bit reflects the live state, not a stored copy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `CIM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CIM_RESP_OKAY;
      if (s_axi_araddr == pwr_addr) begin
        s_axi_rdata <= {28'h000_0000, flags_q, state_q == CIM_PDOWN,
                        state_q == CIM_IDLE}; // RULE15 RULE12
      end else if (s_axi_araddr == stat_addr) begin
        s_axi_rdata <= {29'h0000_0000, state_q};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `CIM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // General flags; the reset sequence reinitialises them with the other special registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 2'(`CIM_PWR_RST >> `CIM_FLAG0_BIT);
    end else if (state_q == CIM_RSTSEQ) begin
      flags_q <= '0;
    end else if (wr_pwr) begin
      flags_q <= wdata_q[`CIM_FLAG1_BIT:`CIM_FLAG0_BIT]; // RULE7
    end
  end

  // Next state; the reset pin outranks every other event.
  always_comb begin
    state_d = state_q;
    case (state_q)
      CIM_RUN: begin
        if (rst_s) begin
          state_d = CIM_RSTSEQ;
        end else if (wr_pwr && wdata_q[`CIM_PDOWN_BIT]) begin
          state_d = CIM_PDOWN; // RULE4
        end else if (wr_pwr && wdata_q[`CIM_IDLE_BIT]) begin
          state_d = CIM_IDLE; // RULE1
        end
      end
      CIM_IDLE, CIM_PDOWN: begin
        if (rst_s) begin
          state_d = CIM_RESUME; // RULE8
        end else if (wake) begin
          state_d = CIM_RUN; // RULE5 RULE4
        end
      end
      CIM_RESUME: begin
        if (resume_cnt_q == 3'h1) begin
          state_d = CIM_RSTSEQ; // RULE9
        end
      end
      CIM_RSTSEQ: begin
        if (!rst_s) begin
          state_d = CIM_RUN;
        end
      end
      default: begin
        state_d = CIM_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CIM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Resumption counter, loaded on the way into the resume window.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_cnt_q <= '0;
    end else if (state_q != CIM_RESUME && state_d == CIM_RESUME) begin
      resume_cnt_q <= `CIM_RESUME_CYC;
    end else if (resume_cnt_q != 3'h0) begin
      resume_cnt_q <= resume_cnt_q - 3'h1;
    end
  end

  // Outputs follow the next state so they line up with the state register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en     <= 1'b1;
      periph_clk_en  <= 1'b1;
      cpu_freeze     <= 1'b0;
      isr_start      <= 1'b0;
      ram_block      <= 1'b0;
      core_reset     <= 1'b0;
      reset_vector   <= `CIM_RESET_VECTOR;
      port0_float    <= 1'b0;
      ale_hold_high  <= 1'b0;
      psen_hold_high <= 1'b0;
    end else begin
      cpu_clk_en     <= state_d != CIM_IDLE && state_d != CIM_PDOWN; // RULE2 RULE8
      periph_clk_en  <= state_d != CIM_PDOWN; // RULE2
      cpu_freeze     <= state_d == CIM_IDLE || state_d == CIM_PDOWN; // RULE3 RULE6
      isr_start      <= (state_q == CIM_IDLE || state_q == CIM_PDOWN) &&
                        state_d == CIM_RUN; // RULE5
      ram_block      <= state_d == CIM_RESUME; // RULE10
      core_reset     <= state_d == CIM_RSTSEQ; // RULE9
      reset_vector   <= `CIM_RESET_VECTOR;
      port0_float    <= (state_d == CIM_IDLE || state_d == CIM_PDOWN) && ext_code; // RULE13
      ale_hold_high  <= state_d == CIM_IDLE; // RULE13
      psen_hold_high <= state_d == CIM_IDLE; // RULE13
    end
  end

  // Checks on entry, exit, gating and the resumption window.
  a_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_RUN && !rst_s && wr_pwr && wdata_q[1:0] == 2'h1
    |=> state_q == CIM_IDLE && !cpu_clk_en) // RULE1
    else $error("idle not entered after idle write");
  a_clk_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_IDLE |-> !cpu_clk_en && periph_clk_en && cpu_freeze) // RULE2 RULE3
    else $error("clock gating wrong in idle");
  a_pdown_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_RUN && !rst_s && wr_pwr && wdata_q[1:0] == 2'h3
    |=> state_q == CIM_PDOWN) // RULE4
    else $error("power-down did not take precedence");
  a_pdown_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_PDOWN && wake && !rst_s |=> state_q == CIM_RUN && isr_start) // RULE4
    else $error("power-down exit did not return to run");
  a_wake_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_IDLE && wake && !rst_s |=> cpu_clk_en && isr_start ##1 !isr_start) // RULE5
    else $error("enabled interrupt did not end idle");
  a_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_IDLE && !wake && !rst_s |=> state_q == CIM_IDLE) // RULE14
    else $error("idle left without enabled interrupt");
  a_rst_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CIM_IDLE && rst_s |=> cpu_clk_en && state_q == CIM_RESUME) // RULE8
    else $error("reset pin did not end idle");
  a_resume_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ram_block) |-> (ram_block && cpu_clk_en && !core_reset)[*4] ##1
    (core_reset && !ram_block)) // RULE9 RULE10
    else $error("resumption window length wrong");
  a_flags_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_pwr && state_q != CIM_RSTSEQ |=> flags_q == $past(wdata_q[3:2])) // RULE7
    else $error("general flags not written");
endmodule

//--- test/cim_core_model.sv
// Model of the CPU core and interrupt system beside the idle controller.
// Assumes one clock and the controller's level outputs on the same domain.
`timescale 1ns/1ps
module cim_core_model
  import cim_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cpu_clk_en,
  input  wire logic        cpu_freeze,
  input  wire logic        isr_start,
  input  wire logic        core_reset,
  input  wire logic [15:0] reset_vector,
  input  wire logic [7:0]  irq_raise,
  output logic [7:0]       irq_pending,
  output logic [15:0]      pc,
  output logic [15:0]      ret_pc
);
  // Requests latch until the handler starts, so a late enable still sees them.
  always_ff @(posedge aclk) begin
    if (!aresetn || isr_start) irq_pending <= 8'h00;
    else irq_pending <= irq_pending | irq_raise;
  end
  // Program counter; the model writes no port or external RAM after an idle request.
  always_ff @(posedge aclk) begin
    if (!aresetn) pc <= 16'h0000;
    else if (core_reset) pc <= reset_vector;
    else if (cpu_clk_en && !cpu_freeze) pc <= pc + 16'h0001;
  end
  // Return address saved as the handler starts.
  always_ff @(posedge aclk) begin
    if (!aresetn) ret_pc <= 16'h0000;
    else if (isr_start) ret_pc <= pc;
  end
endmodule

//--- test/cpu_idle_mode_control_test.sv
// Self-checking bench: register bus, idle, masked wake, power-down, reset pin.
// Assumes the core model beside it and the constants header on the include path.
`timescale 1ns/1ps
`include "cim_params.svh"
module cpu_idle_mode_control_test
  import cim_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, rst_pin, irq_global_en, ext_code;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cpu_clk_en, periph_clk_en, cpu_freeze, isr_start, ram_block, core_reset;
  logic        port0_float, ale_hold_high, psen_hold_high;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fl;
  logic [2:0]  k;
  logic [7:0]  irq_pending, irq_enable, irq_raise;
  logic [15:0] reset_vector, pc, ret_pc, pc_hold;
  int          miscompares = 0, n_checks = 0, cyc = 0, n;
  localparam logic [11:0] A_PWR = 12'(`CIM_PWR_CTRL_IDX * 4);
  localparam logic [11:0] A_STS = 12'(`CIM_STATUS_IDX * 4);

  cim_top i_cim_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rst_pin, .irq_pending, .irq_enable,
    .irq_global_en, .ext_code, .cpu_clk_en, .periph_clk_en, .cpu_freeze, .isr_start,
    .ram_block, .core_reset, .reset_vector, .port0_float, .ale_hold_high, .psen_hold_high);
  cim_core_model i_cim_core_model (.aclk, .aresetn, .cpu_clk_en, .cpu_freeze, .isr_start,
    .core_reset, .reset_vector, .irq_raise, .irq_pending, .pc, .ret_pc);

  // Free-running 10 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Expected power control read: flags, power-down, idle; upper bits read zero.
  function automatic logic [31:0] pwr(input logic [1:0] f, input logic p, input logic i);
    return {28'h000_0000, f, p, i};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bvalid), 32'h0000_0001);
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rvalid), 32'h0000_0001);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // One-cycle request on line k; the model holds it pending.
  task automatic raise();
    @(posedge aclk);
    irq_raise <= 8'h01 << k;
    @(posedge aclk);
    irq_raise <= 8'h00;
  endtask
  task automatic wisr();
    n = 0;
    while (!isr_start && n < 40) begin
      @(posedge aclk);
      n++;
    end
    // A wake that never comes counts as a mismatch here.
    chk(32'(isr_start), 32'h0000_0001);
  endtask

  // Main sequence; samples are read at clock edges, before that edge's updates land.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rst_pin, irq_global_en, ext_code, irq_enable, irq_raise} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    seed = xs(32'h0000_e9f9);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({cpu_clk_en, periph_clk_en, cpu_freeze, core_reset}), 32'h0000_000c);
    axr(A_PWR, pwr(2'b00, 1'b0, 1'b0), `CIM_RESP_OKAY);
    axr(12'h000, 32'h0000_0000, `CIM_RESP_SLVERR);
    axw(12'h004, seed, `CIM_RESP_SLVERR);
    fl = seed[3:2];
    k = seed[6:4];
    axw(A_PWR, {seed[31:4], fl, 2'b00}, `CIM_RESP_OKAY);
    chk(32'(cpu_clk_en), 32'h0000_0001);
    axr(A_PWR, pwr(fl, 1'b0, 1'b0), `CIM_RESP_OKAY);
    ext_code <= seed[8];
    irq_enable <= 8'h01 << k;
    axw(A_PWR, pwr(fl, 1'b0, 1'b1), `CIM_RESP_OKAY);
    chk(32'({cpu_clk_en, periph_clk_en, cpu_freeze}), 32'h0000_0003);
    pc_hold = pc;
    chk(32'({ale_hold_high, psen_hold_high, port0_float}), 32'({2'b11, seed[8]}));
    axr(A_PWR, pwr(fl, 1'b0, 1'b1), `CIM_RESP_OKAY);
    axr(A_STS, 32'h0000_0001, `CIM_RESP_OKAY);
    raise();
    repeat (8) @(posedge aclk);
    chk(32'(cpu_clk_en), 32'h0000_0000);
    irq_global_en <= 1'b1;
    irq_enable <= ~(8'h01 << k);
    repeat (8) @(posedge aclk);
    chk(32'(cpu_clk_en), 32'h0000_0000);
    chk(32'(pc), 32'(pc_hold));
    irq_enable <= 8'h01 << k;
    wisr();
    chk(32'({isr_start, cpu_clk_en}), 32'h0000_0003);
    @(posedge aclk);
    chk(32'(isr_start), 32'h0000_0000);
    chk(32'(ret_pc), 32'(pc_hold));
    axr(A_PWR, pwr(fl, 1'b0, 1'b0), `CIM_RESP_OKAY);
    axw(A_PWR, pwr(fl, 1'b1, 1'b1), `CIM_RESP_OKAY);
    chk(32'({periph_clk_en, cpu_clk_en}), 32'h0000_0000);
    axr(A_STS, 32'h0000_0006, `CIM_RESP_OKAY);
    axr(A_PWR, pwr(fl, 1'b1, 1'b0), `CIM_RESP_OKAY);
    raise();
    wisr();
    axr(A_STS, 32'h0000_0000, `CIM_RESP_OKAY);
    axw(A_PWR, pwr(fl, 1'b0, 1'b1), `CIM_RESP_OKAY);
    rst_pin <= 1'b1;
    n = 0;
    while (!ram_block && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(32'({cpu_clk_en, core_reset}), 32'h0000_0002);
    n = 0;
    while (ram_block && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n), 32'(`CIM_RESUME_CYC));
    chk(32'(core_reset), 32'h0000_0001);
    @(posedge aclk);
    chk(32'(pc), 32'(`CIM_RESET_VECTOR));
    axr(A_PWR, pwr(2'b00, 1'b0, 1'b0), `CIM_RESP_OKAY);
    rst_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(32'({core_reset, cpu_clk_en}), 32'h0000_0001);
    // Reset pin while running goes straight to the reset sequence, no resume window.
    rst_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'({core_reset, ram_block}), 32'h0000_0002);
    rst_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'({core_reset, cpu_clk_en}), 32'h0000_0001);
    complete_run();
  end
endmodule
